/* File: irq_timer_pkg.sv */
package irq_timer_pkg;

  localparam int          NUM_IRQ       = 9;
  localparam int          SEL_W         = 4;
  localparam int          NUM_SRC       = 10;
  localparam logic [31:0] TIMER_MAX     = 32'hFFFFFFFF;
  localparam logic [31:0] VEC_BASE      = 32'h00000000;
  localparam logic [31:0] VEC_STRIDE    = 32'h00000004;

  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0]  OFS_STATUS    = 8'h00;
  localparam logic [7:0]  OFS_MASK      = 8'h04;
  localparam logic [7:0]  OFS_LATCH     = 8'h08;
  localparam logic [7:0]  OFS_LATCH_SET = 8'h0C;
  localparam logic [7:0]  OFS_LATCH_CLR = 8'h10;
  localparam logic [7:0]  OFS_CONFIG    = 8'h14;
  localparam logic [7:0]  OFS_TIMER0    = 8'h18;
  localparam logic [7:0]  OFS_TIMER1    = 8'h1C;
  localparam logic [7:0]  OFS_PEND      = 8'h20;
  localparam logic [7:0]  OFS_EVT_STAT  = 8'h24;
  localparam logic [7:0]  OFS_EVT_MASK  = 8'h28;

  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int          GID_BIT       = 0;
  localparam int          CFG_T0_LSB    = 0;
  localparam int          CFG_T1_LSB    = 4;
  localparam int          NUM_EVT       = 3;
  localparam int          EVT_T0_BIT    = 0;
  localparam int          EVT_T1_BIT    = 1;
  localparam int          EVT_REMOTE    = 2;
  localparam logic [NUM_IRQ-1:0] MASK_RST = 9'h000;

  // interrupt types, latch bit positions
  localparam int IRQ_SYNC          = 0;
  localparam int IRQ_SW_EXCEPTION  = 1;
  localparam int IRQ_MEM_FAULT     = 2;
  localparam int IRQ_TIMER0        = 3;
  localparam int IRQ_TIMER1        = 4;
  localparam int IRQ_MESSAGE       = 5;
  localparam int IRQ_DMA0          = 6;
  localparam int IRQ_DMA1          = 7;
  localparam int IRQ_USER          = 8;

  // timer event-select codes
  localparam logic [SEL_W-1:0] SRC_OFF        = 4'h0;
  localparam logic [SEL_W-1:0] SRC_CLOCK      = 4'h1;
  localparam logic [SEL_W-1:0] SRC_IDLE       = 4'h2;
  localparam logic [SEL_W-1:0] SRC_INT_ALU    = 4'h3;
  localparam logic [SEL_W-1:0] SRC_FLOAT      = 4'h4;
  localparam logic [SEL_W-1:0] SRC_DUAL       = 4'h5;
  localparam logic [SEL_W-1:0] SRC_STAGE      = 4'h6;
  localparam logic [SEL_W-1:0] SRC_REGACCESS  = 4'h7;
  localparam logic [SEL_W-1:0] SRC_EXT_FETCH  = 4'h8;
  localparam logic [SEL_W-1:0] SRC_EXT_LOAD   = 4'h9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REQ  = 2'b10
  } irq_state_t;

endpackage

/* File: event_timer.sv */
`timescale 1ns/1ps
module event_timer
  import irq_timer_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               load_i,
  input  wire logic [31:0]        load_val_i,
  input  wire logic [SEL_W-1:0]   sel_i,
  input  wire logic [NUM_SRC-1:0] events_i,
  output logic      [31:0]        count_o,
  output logic                    expire_o
);

  logic        hit;
  logic        dec;

  // code 0 is off, so a zero source bit stops the count
  assign hit = (sel_i < SEL_W'(NUM_SRC)) ? events_i[sel_i] : 1'b0;
  assign dec = hit && (count_o != 32'h00000000);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      count_o <= 32'h00000000;
    end else if (load_i) begin
      count_o <= (load_val_i > TIMER_MAX) ? TIMER_MAX : load_val_i;
    end else if (dec) begin
      count_o <= count_o - 32'h00000001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      expire_o <= 1'b0;
    end else begin
      expire_o <= !load_i && dec && (count_o == 32'h00000001);
    end
  end

endmodule // event_timer

/* File: core_irq_timers.sv */
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module core_irq_timers
  import irq_timer_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // remote latch access from the workgroup
  input  wire logic [5:0]         my_row_i,
  input  wire logic [5:0]         my_col_i,
  input  wire logic               remote_valid_i,
  input  wire logic [5:0]         remote_row_i,
  input  wire logic [5:0]         remote_col_i,
  input  wire logic               remote_set_i,
  input  wire logic [3:0]         remote_type_i,
  // hardware interrupt sources, one pulse per event
  input  wire logic [NUM_IRQ-1:0] hw_irq_i,
  // timer event sources
  input  wire logic               idle_i,
  input  wire logic               int_alu_i,
  input  wire logic               float_i,
  input  wire logic               dual_issue_i,
  input  wire logic               stage_stall_i,
  input  wire logic               regaccess_stall_i,
  input  wire logic               ext_fetch_stall_i,
  input  wire logic               ext_load_stall_i,
  // core handshake
  output logic                    take_o,
  output logic [3:0]              take_type_o,
  output logic [31:0]             take_vector_o,
  input  wire logic               take_ack_i,
  input  wire logic               service_done_i,
  output logic                    irq_o
);

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [NUM_IRQ-1:0] lowest_set(input logic [NUM_IRQ-1:0] v);
    lowest_set = v & (~v + NUM_IRQ'(1));
  endfunction

  function automatic logic [3:0] onehot_idx(input logic [NUM_IRQ-1:0] v);
    onehot_idx = 4'h0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (v[i]) begin
        onehot_idx = 4'(i);
      end
    end
  endfunction

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic                 gid_r;
  logic [NUM_IRQ-1:0]   mask_r;
  logic [NUM_IRQ-1:0]   latch_r;
  logic [NUM_IRQ-1:0]   latch_nxt;
  logic [NUM_IRQ-1:0]   pend_r;
  logic [NUM_IRQ-1:0]   pend_nxt;
  logic [SEL_W-1:0]     sel0_r;
  logic [SEL_W-1:0]     sel1_r;
  logic [NUM_EVT-1:0]   evt_stat_r;
  logic [NUM_EVT-1:0]   evt_mask_r;
  logic [NUM_IRQ-1:0]   pick_r;
  irq_state_t           state_r;
  irq_state_t           state_nxt;

  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic [31:0]          rd_data;
  logic [31:0]          count0;
  logic [31:0]          count1;
  logic                 expire0;
  logic                 expire1;
  logic [NUM_SRC-1:0]   src_vec;
  logic                 remote_hit;
  logic [NUM_IRQ-1:0]   remote_bit;
  logic [NUM_IRQ-1:0]   set_bits;
  logic [NUM_IRQ-1:0]   clr_bits;
  logic [NUM_IRQ-1:0]   allowed;
  logic [NUM_IRQ-1:0]   candidate;
  logic [NUM_IRQ-1:0]   ack_bits;
  logic [NUM_EVT-1:0]   evt_set;

  // -------------------------------------------------------------------
  // apb slave: one wait state, answer two cycles after setup
  // -------------------------------------------------------------------
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h00000000;
    case (paddr)
      OFS_STATUS:    rd_data[GID_BIT] = gid_r;
      OFS_MASK:      rd_data[NUM_IRQ-1:0] = mask_r;
      OFS_LATCH:     rd_data[NUM_IRQ-1:0] = latch_r;
      OFS_LATCH_SET: rd_data = 32'h00000000;
      OFS_LATCH_CLR: rd_data = 32'h00000000;
      OFS_CONFIG: begin
        rd_data[CFG_T0_LSB +: SEL_W] = sel0_r;
        rd_data[CFG_T1_LSB +: SEL_W] = sel1_r;
      end
      OFS_TIMER0:    rd_data = count0;
      OFS_TIMER1:    rd_data = count1;
      OFS_PEND:      rd_data[NUM_IRQ-1:0] = pend_r;
      OFS_EVT_STAT:  rd_data[NUM_EVT-1:0] = evt_stat_r;
      OFS_EVT_MASK:  rd_data[NUM_EVT-1:0] = evt_mask_r;
      default:       addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= rd_en ? rd_data : 32'h00000000;
      pslverr <= !addr_ok;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      gid_r <= 1'b0;
    end else if (wr_en && paddr == OFS_STATUS) begin
      gid_r <= pwdata[GID_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mask_r <= MASK_RST;
    end else if (wr_en && paddr == OFS_MASK) begin
      mask_r <= pwdata[NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sel0_r <= SRC_OFF;
      sel1_r <= SRC_OFF;
    end else if (wr_en && paddr == OFS_CONFIG) begin
      sel0_r <= pwdata[CFG_T0_LSB +: SEL_W];
      sel1_r <= pwdata[CFG_T1_LSB +: SEL_W];
    end
  end

  // -------------------------------------------------------------------
  // event timers
  // -------------------------------------------------------------------
  assign src_vec = {ext_load_stall_i, ext_fetch_stall_i, regaccess_stall_i,
                    stage_stall_i, dual_issue_i, float_i, int_alu_i, idle_i,
                    1'b1, 1'b0};

  event_timer u_timer0 (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (wr_en && paddr == OFS_TIMER0),
    .load_val_i (pwdata),
    .sel_i      (sel0_r),
    .events_i   (src_vec),
    .count_o    (count0),
    .expire_o   (expire0)
  );

  event_timer u_timer1 (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (wr_en && paddr == OFS_TIMER1),
    .load_val_i (pwdata),
    .sel_i      (sel1_r),
    .events_i   (src_vec),
    .count_o    (count1),
    .expire_o   (expire1)
  );

  // -------------------------------------------------------------------
  // interrupt latch
  // -------------------------------------------------------------------
  assign remote_hit = remote_valid_i && (remote_row_i == my_row_i) &&
                      (remote_col_i == my_col_i) &&
                      (remote_type_i < 4'(NUM_IRQ));
  assign remote_bit = remote_hit ? (NUM_IRQ'(1) << remote_type_i) : '0;

  // hardware and remote sets always win over any clear in the same cycle
  always_comb begin
    set_bits = hw_irq_i;
    set_bits[IRQ_TIMER0] = hw_irq_i[IRQ_TIMER0] | expire0;
    set_bits[IRQ_TIMER1] = hw_irq_i[IRQ_TIMER1] | expire1;
    clr_bits = '0;
    if (remote_set_i) begin
      set_bits = set_bits | remote_bit;
    end else begin
      clr_bits = remote_bit;
    end
    if (wr_en && paddr == OFS_LATCH_SET) begin
      set_bits = set_bits | pwdata[NUM_IRQ-1:0];
    end
    if (wr_en && paddr == OFS_LATCH_CLR) begin
      clr_bits = clr_bits | pwdata[NUM_IRQ-1:0];
    end
  end

  assign ack_bits = (state_r == ST_REQ && take_ack_i) ? pick_r : '0;

  always_comb begin
    latch_nxt = latch_r & ~clr_bits & ~ack_bits;
    if (wr_en && paddr == OFS_LATCH) begin
      latch_nxt = pwdata[NUM_IRQ-1:0];
    end
    latch_nxt = latch_nxt | set_bits;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      latch_r <= '0;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // -------------------------------------------------------------------
  // qualification and dispatch
  // -------------------------------------------------------------------
  // only types above the one in service may nest; bit 0 ranks highest
  assign allowed   = (pend_r == '0) ? '1 : (lowest_set(pend_r) - NUM_IRQ'(1));
  assign candidate = gid_r ? '0 : lowest_set(latch_r & ~mask_r & allowed);

  always_comb begin
    pend_nxt = pend_r | ack_bits;
    if (service_done_i) begin
      pend_nxt = (pend_r & ~lowest_set(pend_r)) | ack_bits;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (candidate != '0) begin
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        // a request cleared before the core takes it is dropped
        if (take_ack_i || ((pick_r & candidate) == '0)) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      pick_r  <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        pick_r <= candidate;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      take_o        <= 1'b0;
      take_type_o   <= 4'h0;
      take_vector_o <= 32'h00000000;
    end else begin
      take_o <= (state_nxt == ST_REQ);
      if (state_r == ST_IDLE) begin
        take_type_o   <= onehot_idx(candidate);
        take_vector_o <= VEC_BASE + VEC_STRIDE * 32'(onehot_idx(candidate));
      end
    end
  end

  // -------------------------------------------------------------------
  // block events: sticky, write one to clear, set wins
  // -------------------------------------------------------------------
  assign evt_set = {remote_hit, expire1, expire0};

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      evt_stat_r <= '0;
    end else begin
      evt_stat_r <= (evt_stat_r & ~((wr_en && paddr == OFS_EVT_STAT) ?
                     pwdata[NUM_EVT-1:0] : '0)) | evt_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      evt_mask_r <= '0;
    end else if (wr_en && paddr == OFS_EVT_MASK) begin
      evt_mask_r <= pwdata[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(evt_stat_r & evt_mask_r);
    end
  end

endmodule // core_irq_timers

/* File: core_irq_timers_assertions.sv */
`timescale 1ns/1ps
module core_irq_timers_assertions
  import irq_timer_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        take_o,
  input  wire logic [3:0]  take_type_o,
  input  wire logic [31:0] take_vector_o,
  input  wire logic        take_ack_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ---------------------------------------------------------------
  // shadow of mask and global disable, one cycle late to match take_o
  // ---------------------------------------------------------------
  logic [NUM_IRQ-1:0] mask_r, mask_p;
  logic               gid_r, gid_p;
  logic               wr_hit;
  assign wr_hit = psel && penable && pready && pwrite;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) mask_r <= MASK_RST;
    else if (wr_hit && paddr == OFS_MASK) mask_r <= pwdata[NUM_IRQ-1:0];
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) gid_r <= 1'b0;
    else if (wr_hit && paddr == OFS_STATUS) gid_r <= pwdata[GID_BIT];
  end
  always_ff @(posedge mclk_i) begin
    mask_p <= sys_rst_i ? MASK_RST : mask_r;
    gid_p  <= !sys_rst_i && gid_r;
  end
  sequence s_access;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  access_ready_a: assert property (s_access |=> pready)
    else $error("no answer after access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  ack_drops_take_a: assert property (take_o && take_ack_i |=> !take_o)
    else $error("request stands after ack");
  vector_entry_a: assert property (take_o |->
    take_vector_o == VEC_BASE + VEC_STRIDE * {28'h0, take_type_o})
    else $error("vector does not match type");
  type_range_a: assert property (take_o |-> take_type_o < 4'(NUM_IRQ))
    else $error("type out of range");
  take_qualified_a: assert property ($rose(take_o) |-> !gid_p && !mask_p[take_type_o])
    else $error("masked or disabled request taken");
endmodule // core_irq_timers_assertions

bind core_irq_timers core_irq_timers_assertions u_chk (.mclk_i, .sys_rst_i, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .take_o,
  .take_type_o, .take_vector_o, .take_ack_i);

/* File: core_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// local core: accepts a request after lat_i cycles, returns later
// ---------------------------------------------------------------
module core_model (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       take_o,
  input  wire logic [3:0] lat_i,
  output logic            take_ack_o,
  output logic            done_o
);
  logic [3:0] wait_r;
  logic [2:0] ret_r;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !take_o || take_ack_o) wait_r <= 4'h0;
    else wait_r <= wait_r + 4'h1;
  end
  // a single-cycle accept, only while the request stands
  always_ff @(posedge mclk_i) begin
    take_ack_o <= !sys_rst_i && take_o && !take_ack_o && wait_r >= lat_i;
  end
  always_ff @(posedge mclk_i) begin
    ret_r  <= sys_rst_i ? 3'h0 : {ret_r[1:0], take_ack_o};
    done_o <= !sys_rst_i && ret_r[2];
  end
endmodule // core_model

/* File: core_irq_timers_tb.sv */
`timescale 1ns/1ps
module core_irq_timers_tb;
  import irq_timer_pkg::*;
  logic               mclk_i, sys_rst_i, psel, penable, pwrite;
  logic               pready, pslverr, take_o, take_ack_i, done, irq_o, rv, rs;
  logic [7:0]         paddr, ev;
  logic [31:0]        pwdata, prdata, take_vector_o;
  logic [5:0]         rc, rr, myr, myc;
  logic [3:0]         rt, take_type_o, lat;
  logic [NUM_IRQ-1:0] hw;
  logic [31:0]        rq[$];
  logic [3:0]         tq[$];
  int                 bad_count, samples_checked, seed;

  core_irq_timers dut (.mclk_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .my_row_i(myr), .my_col_i(myc), .remote_valid_i(rv),
    .remote_row_i(rr), .remote_col_i(rc), .remote_set_i(rs), .remote_type_i(rt),
    .hw_irq_i(hw), .idle_i(ev[0]), .int_alu_i(ev[1]), .float_i(ev[2]),
    .dual_issue_i(ev[3]), .stage_stall_i(ev[4]), .regaccess_stall_i(ev[5]),
    .ext_fetch_stall_i(ev[6]), .ext_load_stall_i(ev[7]), .take_o, .take_type_o,
    .take_vector_o, .take_ack_i, .service_done_i(done), .irq_o);
  core_model u_core (.mclk_i, .sys_rst_i, .take_o, .lat_i(lat), .take_ack_o(take_ack_i),
    .done_o(done));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic fail(input string m);
    bad_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk_i);
    end
    samples_checked++;
    if (pready !== 1'b1) fail("no ready");
    if (pslverr !== e) fail("error flag");
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following setup never reassigns psel in this step
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    apb(1'b0, a, 32'h0, 1'b0);
  endtask
  task automatic remote(input logic [5:0] r, input logic [5:0] c, input logic s,
                        input logic [3:0] t);
    rr <= r;
    rc <= c;
    rs <= s;
    rt <= t;
    rv <= 1'b1;
    @(posedge mclk_i);
    rv <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic chk_irq(input logic b);
    samples_checked++;
    if (irq_o !== b) fail("irq level");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // result watcher: oldest expectation against each answer
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      samples_checked++;
      if (rq.size() == 0) fail("stray read");
      else if (prdata !== rq.pop_front()) fail("read data");
    end
    if (take_o === 1'b1 && take_ack_i === 1'b1) begin
      samples_checked++;
      if (tq.size() == 0) fail("stray take");
      else begin
        if (take_type_o !== tq[0] ||
            take_vector_o !== VEC_BASE + VEC_STRIDE * 32'(tq[0]))
          fail("take type");
        void'(tq.pop_front());
      end
    end
  end
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h2492B4A6;
    {psel, penable, pwrite, rv, rs, paddr, pwdata, rc, rr, rt, hw, ev, lat} = '0;
    myr = 6'($random(seed));
    myc = 6'($random(seed));
    sys_rst_i = 1'b1;
    idle(16);
    sys_rst_i <= 1'b0;
    rd(OFS_MASK, 32'h0);
    rd(OFS_CONFIG, 32'h0);
    rq.push_back(32'h0);
    apb(1'b0, 8'h3C, 32'h0, 1'b1);
    for (int t = 0; t < NUM_IRQ; t++) begin
      lat <= 4'($random(seed)) & 4'h3;
      tq.push_back(4'(t));
      wr(OFS_LATCH_SET, 32'h1 << t);
      idle(14);
    end
    wr(OFS_MASK, 32'h20);
    wr(OFS_LATCH_SET, 32'h20);
    idle(8);
    rd(OFS_LATCH, 32'h20);
    wr(OFS_LATCH_CLR, 32'h20);
    wr(OFS_MASK, 32'h0);
    idle(8);
    rd(OFS_LATCH, 32'h0);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_LATCH_SET, 32'h4);
    idle(8);
    tq.push_back(4'h2);
    wr(OFS_STATUS, 32'h0);
    idle(14);
    tq.push_back(4'h6);
    remote(myr, myc, 1'b1, 4'h6);
    idle(14);
    remote(myr, myc + 6'h01, 1'b1, 4'h7);
    remote(myr + 6'h01, myc, 1'b1, 4'h7);
    wr(OFS_STATUS, 32'h1);
    remote(myr, myc, 1'b1, 4'h7);
    remote(myr, myc, 1'b0, 4'h7);
    wr(OFS_STATUS, 32'h0);
    idle(8);
    rd(OFS_LATCH, 32'h0);
    tq.push_back(4'h8);
    hw <= 9'h100;
    idle(1);
    hw <= 9'h000;
    idle(14);
    wr(OFS_TIMER0, 32'd100);
    wr(OFS_CONFIG, 32'(SRC_CLOCK));
    wr(OFS_CONFIG, 32'h0);
    // the clock select stands for four edges before the off write lands
    rd(OFS_TIMER0, 32'd96);
    idle(5);
    rd(OFS_TIMER0, 32'd96);
    wr(OFS_EVT_STAT, 32'h7);
    tq.push_back(4'h3);
    wr(OFS_TIMER0, 32'd2);
    wr(OFS_CONFIG, 32'(SRC_CLOCK));
    idle(14);
    rd(OFS_TIMER0, 32'h0);
    wr(OFS_CONFIG, 32'h0);
    chk_irq(1'b0);
    wr(OFS_EVT_MASK, 32'h1);
    idle(2);
    chk_irq(1'b1);
    rd(OFS_EVT_STAT, 32'h1);
    wr(OFS_EVT_STAT, 32'h1);
    idle(2);
    chk_irq(1'b0);
    wr(OFS_TIMER1, 32'hFFFFFFFF);
    rd(OFS_TIMER1, 32'hFFFFFFFF);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_TIMER1, 32'd50);
      wr(OFS_CONFIG, 32'(k + 2) << CFG_T1_LSB);
      ev <= 8'(1 << k);
      idle(1);
      repeat (4) begin
        ev <= 8'($random(seed)) & ~8'(1 << k);
        idle(1);
      end
      ev <= 8'h00;
      wr(OFS_CONFIG, 32'h0);
      rd(OFS_TIMER1, 32'd49);
    end
    idle(4);
    if (tq.size() != 0) fail("missing take");
    conclude();
  end
endmodule // core_irq_timers_tb
